// ==== hw/sc_guard.sv ====
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module sc_guard (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [17:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Baud timing and character engines, same clock
  input wire logic i_etu_tick,
  input wire logic i_rx_start,
  input wire logic i_rx_char_done,
  input wire logic [7:0] i_rx_char_raw,
  input wire logic i_tx_start,
  input wire logic i_card_break,
  // Card power, asynchronous
  input wire logic i_card_supply_good,
  // Outputs
  output logic o_tx_start_ok,
  output logic o_direct_conv,
  output logic [1:0] o_card_rst_n,
  output logic o_irq
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] block_guard_ctrl_q;
  logic [7:0] extra_guard_low_q;
  logic [7:0] answer_timeout_high_q;
  logic [7:0] answer_timeout_low_q;
  logic [7:0] first_char_timeout_q;
  logic [7:0] reset_release_delay_q;
  logic [7:0] ctrl_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic [2:0] events;
  logic direct_q;
  logic ts_seen;

  logic access;
  logic wr;
  logic [15:0] idx;
  logic aligned;
  logic hit;
  logic [7:0] wd;

  assign access = i_psel & i_penable & o_pready;
  assign wr = access & i_pwrite;
  assign idx = i_paddr[17:2];
  assign aligned = (i_paddr[1:0] == 2'h0);
  assign wd = i_pwdata[7:0];

  always_comb begin
    case (idx)
      sc_guard_pkg::IDX_BLOCK_GUARD,
      sc_guard_pkg::IDX_EXTRA_GUARD,
      sc_guard_pkg::IDX_ANS_TO_HIGH,
      sc_guard_pkg::IDX_ANS_TO_LOW,
      sc_guard_pkg::IDX_FIRST_TO,
      sc_guard_pkg::IDX_RST_DELAY,
      sc_guard_pkg::IDX_CTRL,
      sc_guard_pkg::IDX_IRQ_STATUS,
      sc_guard_pkg::IDX_IRQ_MASK,
      sc_guard_pkg::IDX_STATE: hit = aligned;
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait slave: ready comes up for the access cycle only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~hit;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      block_guard_ctrl_q <= sc_guard_pkg::RST_BLOCK_GUARD;
      extra_guard_low_q <= sc_guard_pkg::RST_EXTRA_GUARD;
      answer_timeout_high_q <= sc_guard_pkg::RST_ANS_TO;
      answer_timeout_low_q <= sc_guard_pkg::RST_ANS_TO;
      first_char_timeout_q <= sc_guard_pkg::RST_FIRST_TO;
      reset_release_delay_q <= sc_guard_pkg::RST_RST_DELAY;
      irq_mask_q <= sc_guard_pkg::RST_IRQ;
    end else if (wr) begin
      case (idx)
        sc_guard_pkg::IDX_BLOCK_GUARD: block_guard_ctrl_q <= wd & 8'h9F;
        sc_guard_pkg::IDX_EXTRA_GUARD: extra_guard_low_q <= wd;
        sc_guard_pkg::IDX_ANS_TO_HIGH: answer_timeout_high_q <= wd;
        sc_guard_pkg::IDX_ANS_TO_LOW: answer_timeout_low_q <= wd;
        sc_guard_pkg::IDX_FIRST_TO: first_char_timeout_q <= wd;
        sc_guard_pkg::IDX_RST_DELAY: reset_release_delay_q <= wd;
        sc_guard_pkg::IDX_IRQ_MASK: irq_mask_q <= wd[2:0];
        default: begin
        end
      endcase
    end
  end

  // Control: a software write wins over the hardware clear of detection
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= sc_guard_pkg::RST_CTRL;
    end else if (wr && idx == sc_guard_pkg::IDX_CTRL) begin
      ctrl_q <= wd & 8'h1F;
    end else if (ts_seen) begin
      ctrl_q[sc_guard_pkg::CTRL_DETECT] <= 1'b0;
    end
  end

  // Sticky events, cleared by writing one; a new event beats the clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status_q <= sc_guard_pkg::RST_IRQ;
    end else if (wr && idx == sc_guard_pkg::IDX_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~wd[2:0]) | events;
    end else begin
      irq_status_q <= irq_status_q | events;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_q & irq_mask_q);
    end
  end

  logic [7:0] rd;
  logic tx_ok_d;
  logic released;

  always_comb begin
    case (idx)
      sc_guard_pkg::IDX_BLOCK_GUARD: rd = block_guard_ctrl_q;
      sc_guard_pkg::IDX_EXTRA_GUARD: rd = extra_guard_low_q;
      sc_guard_pkg::IDX_ANS_TO_HIGH: rd = answer_timeout_high_q;
      sc_guard_pkg::IDX_ANS_TO_LOW: rd = answer_timeout_low_q;
      sc_guard_pkg::IDX_FIRST_TO: rd = first_char_timeout_q;
      sc_guard_pkg::IDX_RST_DELAY: rd = reset_release_delay_q;
      sc_guard_pkg::IDX_CTRL: rd = ctrl_q;
      sc_guard_pkg::IDX_IRQ_STATUS: rd = {5'h00, irq_status_q};
      sc_guard_pkg::IDX_IRQ_MASK: rd = {5'h00, irq_mask_q};
      sc_guard_pkg::IDX_STATE: rd = {5'h00, released, tx_ok_d, direct_q};
      default: rd = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      o_prdata <= hit ? {24'h00_0000, rd} : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Guard times
  // ----------------------------------------
  logic t1_mode;
  logic [8:0] egt_prog;
  logic [8:0] egt_floor;
  logic [8:0] egt_eff;
  logic [8:0] tx_gap_q;
  logic [4:0] bg_cnt_q;
  logic rx_last_q;

  assign t1_mode = ctrl_q[sc_guard_pkg::CTRL_T1];
  assign egt_prog = {block_guard_ctrl_q[sc_guard_pkg::BG_EGT_MSB],
                     extra_guard_low_q};
  assign egt_floor = t1_mode ? sc_guard_pkg::EGT_MIN_T1
                             : sc_guard_pkg::EGT_MIN_T0;
  assign egt_eff = (egt_prog < egt_floor) ? egt_floor : egt_prog;

  // Units since the last transmitted start edge; saturates at the top
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_gap_q <= 9'h1FF;
    end else if (i_tx_start) begin
      tx_gap_q <= 9'h000;
    end else if (i_card_break && !t1_mode) begin
      // Restarting the gap pushes the next start a full guard out
      tx_gap_q <= 9'h000;
    end else if (i_etu_tick && tx_gap_q != 9'h1FF) begin
      tx_gap_q <= tx_gap_q + 9'h001;
    end
  end

  // Units since the last received start edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bg_cnt_q <= 5'h1F;
    end else if (i_rx_start) begin
      bg_cnt_q <= 5'h00;
    end else if (i_etu_tick && bg_cnt_q != 5'h1F) begin
      bg_cnt_q <= bg_cnt_q + 5'h01;
    end
  end

  // Set when reception was the latest traffic, so the next send is a first
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_last_q <= 1'b0;
    end else if (i_rx_start) begin
      rx_last_q <= 1'b1;
    end else if (i_tx_start) begin
      rx_last_q <= 1'b0;
    end
  end

  // A saturated block count of 31 still meets the widest 5-bit guard
  assign tx_ok_d = rx_last_q
                 ? (bg_cnt_q >= block_guard_ctrl_q[4:0])
                 : (tx_gap_q >= egt_eff);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_start_ok <= 1'b0;
    end else begin
      o_tx_start_ok <= tx_ok_d & ~i_tx_start & ~i_rx_start;
    end
  end

  // ----------------------------------------
  // Answer and first-character timers
  // ----------------------------------------
  logic [16:0] ans_cnt_q;
  logic ans_run_q;
  logic ans_fire;
  logic [15:0] ans_limit;
  logic [8:0] fc_cnt_q;
  logic fc_run_q;
  logic fc_fire;
  logic rel_edge;

  assign ans_limit = {answer_timeout_high_q, answer_timeout_low_q};
  assign ans_fire = ans_run_q && i_etu_tick &&
                    ans_cnt_q == {1'b0, ans_limit};

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ans_run_q <= 1'b0;
      ans_cnt_q <= 17'h0_0000;
    end else if (!ctrl_q[sc_guard_pkg::CTRL_RX_ANSWER]) begin
      ans_run_q <= 1'b0;
      ans_cnt_q <= 17'h0_0000;
    end else if (!ans_run_q && ans_cnt_q == 17'h0_0000 && i_rx_start) begin
      ans_run_q <= 1'b1;
    end else if (ans_run_q && i_etu_tick) begin
      ans_cnt_q <= ans_cnt_q + 17'h0_0001;
      if (ans_fire) begin
        // Stop after one report; stays idle until CTRL_RX_ANSWER is cleared
        ans_run_q <= 1'b0;
        ans_cnt_q <= 17'h1_0000;
      end
    end
  end

  assign fc_fire = fc_run_q && i_etu_tick &&
                   fc_cnt_q == {1'b0, first_char_timeout_q};

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fc_run_q <= 1'b0;
      fc_cnt_q <= 9'h000;
    end else if (rel_edge && ctrl_q[sc_guard_pkg::CTRL_DETECT]) begin
      fc_run_q <= 1'b1;
      fc_cnt_q <= 9'h000;
    end else if (i_rx_start || fc_fire ||
                 !ctrl_q[sc_guard_pkg::CTRL_DETECT]) begin
      fc_run_q <= 1'b0;
    end else if (fc_run_q && i_etu_tick) begin
      fc_cnt_q <= fc_cnt_q + 9'h001;
    end
  end

  // ----------------------------------------
  // TS detection
  // ----------------------------------------
  assign ts_seen = i_rx_char_done & ctrl_q[sc_guard_pkg::CTRL_DETECT];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      direct_q <= 1'b1;
    end else if (ts_seen) begin
      direct_q <= (i_rx_char_raw == sc_guard_pkg::TS_DIRECT);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_direct_conv <= 1'b1;
    end else begin
      o_direct_conv <= direct_q;
    end
  end

  always_comb begin
    events = 3'h0;
    events[sc_guard_pkg::EV_ANSWER_TO] = ans_fire | fc_fire;
    events[sc_guard_pkg::EV_MUTE] = fc_fire;
    events[sc_guard_pkg::EV_TS_DONE] = ts_seen;
  end

  // ----------------------------------------
  // Card reset sequencing
  // ----------------------------------------
  logic supply_meta_q;
  logic supply_q;
  sc_guard_pkg::rst_state_t rst_state_q;
  logic [7:0] rst_cnt_q;
  logic hold;
  logic sel_q;
  logic [1:0] card_rel_q;

  assign hold = ctrl_q[sc_guard_pkg::CTRL_HOLD];
  assign released = (rst_state_q == sc_guard_pkg::RS_RELEASED);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply_meta_q <= 1'b0;
      supply_q <= 1'b0;
    end else begin
      supply_meta_q <= i_card_supply_good;
      supply_q <= supply_meta_q;
    end
  end

  // Sequencer restarts whenever another card is chosen
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= ctrl_q[sc_guard_pkg::CTRL_SEL];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_state_q <= sc_guard_pkg::RS_HELD;
      rst_cnt_q <= 8'h00;
    end else if (hold || !supply_q ||
                 sel_q != ctrl_q[sc_guard_pkg::CTRL_SEL]) begin
      rst_state_q <= sc_guard_pkg::RS_HELD;
      rst_cnt_q <= 8'h00;
    end else begin
      case (rst_state_q)
        sc_guard_pkg::RS_HELD: begin
          rst_cnt_q <= 8'h00;
          if (reset_release_delay_q == 8'h00) begin
            rst_state_q <= sc_guard_pkg::RS_RELEASED;
          end else begin
            rst_state_q <= sc_guard_pkg::RS_DELAY;
          end
        end
        sc_guard_pkg::RS_DELAY: begin
          if (rst_cnt_q >= reset_release_delay_q) begin
            rst_state_q <= sc_guard_pkg::RS_RELEASED;
          end else if (i_etu_tick) begin
            rst_cnt_q <= rst_cnt_q + 8'h01;
          end
        end
        sc_guard_pkg::RS_RELEASED: rst_state_q <= sc_guard_pkg::RS_RELEASED;
        default: rst_state_q <= sc_guard_pkg::RS_HELD;
      endcase
    end
  end

  // Release edge of the selected card starts the first-character timer
  assign rel_edge = released & ~card_rel_q[sel_q];

  genvar c;
  generate
    for (c = 0; c < sc_guard_pkg::NUM_CARDS; c = c + 1) begin : g_card
      // Only the selected card follows the sequencer; others keep level
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          card_rel_q[c] <= 1'b0;
        end else if (sel_q == 1'(c) &&
                     sel_q == ctrl_q[sc_guard_pkg::CTRL_SEL]) begin
          card_rel_q[c] <= released;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_card_rst_n <= 2'h0;
    end else begin
      o_card_rst_n <= card_rel_q;
    end
  end

endmodule
`default_nettype wire

// ==== hw/sc_guard_pkg.sv ====
// What this block does
// - Extra guard is nine bits: block guard bit 7 over low byte.
// - Extra guard never below 12 units in T=0 or 11 in T=1.
// - In T=0 a card break postpones the next transmitted start bit.
// - First transmitted character waits block guard after last received start.
// - Block guard time comes from bits 4 to 0, reset to 16 units.
// - Answer timer armed by receive flag, starts at first start bit.
// - Answer timeout when answer spans longer than the 16-bit limit.
// - First-char timer starts at reset release while detection requested.
// - First-char timer overrun raises answer timeout, card is mute.
// - Zero delay and hold clear release reset once supply is good.
// - Nonzero delay postpones reset release by that many units.
// - Setting the hold bit drives card reset low.
// - Clearing the hold bit releases reset after the programmed delay.
// - Hold set before power keeps reset low until cleared plus delay.
// - Reset sequencing acts on the selected card interface.
// - Detection request treats next character as TS, then clears.
package sc_guard_pkg;
  localparam int unsigned NUM_CARDS = 2;
  localparam int unsigned ADDR_W = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BLOCK_GUARD = 16'hFE16;
  localparam logic [15:0] IDX_EXTRA_GUARD = 16'hFE17;
  localparam logic [15:0] IDX_ANS_TO_HIGH = 16'hFE1F;
  localparam logic [15:0] IDX_ANS_TO_LOW = 16'hFE20;
  localparam logic [15:0] IDX_FIRST_TO = 16'hFE21;
  localparam logic [15:0] IDX_RST_DELAY = 16'hFE22;
  localparam logic [15:0] IDX_CTRL = 16'hFE30;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hFE31;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFE32;
  localparam logic [15:0] IDX_STATE = 16'hFE33;
  // Reset values
  localparam logic [7:0] RST_BLOCK_GUARD = 8'h10;
  localparam logic [7:0] RST_EXTRA_GUARD = 8'h0C;
  localparam logic [7:0] RST_ANS_TO = 8'h00;
  localparam logic [7:0] RST_FIRST_TO = 8'h00;
  localparam logic [7:0] RST_RST_DELAY = 8'h70;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // Field positions
  localparam int unsigned BG_EGT_MSB = 7;
  localparam int unsigned CTRL_T1 = 0;
  localparam int unsigned CTRL_HOLD = 1;
  localparam int unsigned CTRL_RX_ANSWER = 2;
  localparam int unsigned CTRL_DETECT = 3;
  localparam int unsigned CTRL_SEL = 4;
  localparam int unsigned EV_ANSWER_TO = 0;
  localparam int unsigned EV_MUTE = 1;
  localparam int unsigned EV_TS_DONE = 2;
  localparam int unsigned ST_DIRECT = 0;
  localparam int unsigned ST_TX_OK = 1;
  localparam int unsigned ST_RELEASED = 2;
  // Guard floors in elementary time units
  localparam logic [8:0] EGT_MIN_T0 = 9'h00C;
  localparam logic [8:0] EGT_MIN_T1 = 9'h00B;
  // Raw TS byte that signals direct convention
  localparam logic [7:0] TS_DIRECT = 8'h3B;
  typedef enum logic [1:0] {RS_HELD, RS_DELAY, RS_RELEASED} rst_state_t;
endpackage

// ==== verif/sc_card_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sc_card_model (
  // Clock, reset and unit tick
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  // Card reset and bench commands
  input wire logic i_card_rst_n,
  input wire logic i_mute,
  input wire logic i_send,
  input wire logic i_brk,
  input wire logic [7:0] i_byte,
  // Character events towards the device
  output logic o_rx_start,
  output logic o_rx_done,
  output logic o_break,
  output logic [7:0] o_raw
);
  logic rst_q;
  logic [3:0] left_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q <= 1'b0;
      left_q <= 4'h0;
      o_rx_start <= 1'b0;
      o_rx_done <= 1'b0;
      o_break <= 1'b0;
      o_raw <= 8'h00;
    end else begin
      rst_q <= i_card_rst_n;
      o_break <= i_brk;
      o_rx_start <= 1'b0;
      o_rx_done <= 1'b0;
      // Byte is only meaningful with done, so it churns otherwise
      o_raw <= ~o_raw;
      if (i_send || (i_card_rst_n && !rst_q && !i_mute)) begin
        o_rx_start <= 1'b1;
        left_q <= 4'hA;
      end else if (i_tick && left_q != 4'h0) begin
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1) begin
          o_rx_done <= 1'b1;
          o_raw <= i_byte;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/sc_guard_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module sc_guard_chk (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Character and card side
  input wire logic i_etu_tick,
  input wire logic i_rx_start,
  input wire logic i_rx_char_done,
  input wire logic i_tx_start,
  input wire logic i_card_supply_good,
  input wire logic o_tx_start_ok,
  input wire logic o_direct_conv,
  input wire logic [1:0] o_card_rst_n,
  input wire logic o_irq
);
  // --------------------------------------------------------------
  // Unit gap since the last transmitted start
  // --------------------------------------------------------------
  // Mode is not visible here, so the lower T=1 floor is checked
  logic [8:0] gap_q;
  logic last_tx_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_q <= 9'h000;
      last_tx_q <= 1'b0;
    end else begin
      if (i_tx_start) begin
        gap_q <= 9'h000;
      end else if (i_etu_tick && gap_q != 9'h1FF) begin
        gap_q <= gap_q + 9'h001;
      end
      if (i_tx_start) begin
        last_tx_q <= 1'b1;
      end else if (i_rx_start) begin
        last_tx_q <= 1'b0;
      end
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  tx_drop_a: assert property (i_tx_start |=> !o_tx_start_ok)
    else $error("tx ok high after tx start");
  rx_drop_a: assert property (i_rx_start |=> !o_tx_start_ok)
    else $error("tx ok high after rx start");
  tx_gap_a: assert property (o_tx_start_ok && last_tx_q |-> gap_q >= 9'd11)
    else $error("tx ok before guard floor");
  rst_supply_a: assert property ($rose(o_card_rst_n[0]) |->
    $past(i_card_supply_good, 3))
    else $error("card reset released without supply");
  ts_conv_a: assert property ($changed(o_direct_conv) |->
    $past(i_rx_char_done, 2))
    else $error("convention changed without a character");
  ack_setup_a: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("pready without setup");
  err_ack_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  rdata_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  cover property (i_tx_start ##1 !o_tx_start_ok);
  cover property ($rose(o_card_rst_n[1]));
  cover property ($rose(o_irq));
endmodule
bind sc_guard sc_guard_chk chk_u (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_etu_tick(i_etu_tick),
  .i_rx_start(i_rx_start), .i_rx_char_done(i_rx_char_done),
  .i_tx_start(i_tx_start), .i_card_supply_good(i_card_supply_good),
  .o_tx_start_ok(o_tx_start_ok), .o_direct_conv(o_direct_conv),
  .o_card_rst_n(o_card_rst_n), .o_irq(o_irq)
);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic i_core_clk, i_rst_n, psel, penable, pwrite, tick, tx, brk, send;
  logic mute, sup, pready, pslverr, rxs, rxd, cbrk, txok, dconv, irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [7:0] raw, tbyte;
  logic [1:0] crst;
  logic [32:0] expq [$];
  logic [32:0] exp_v;
  integer seed = 32'hA250, mismatches = 0, tests_run = 0, cycles = 0;
  integer i, j;
  logic [15:0] idx_t [6] = '{sc_guard_pkg::IDX_BLOCK_GUARD,
    sc_guard_pkg::IDX_EXTRA_GUARD, sc_guard_pkg::IDX_ANS_TO_HIGH,
    sc_guard_pkg::IDX_ANS_TO_LOW, sc_guard_pkg::IDX_FIRST_TO,
    sc_guard_pkg::IDX_RST_DELAY};
  logic [7:0] rst_t [6] = '{8'h10, 8'h0C, 8'h00, 8'h00, 8'h00, 8'h70};
  // Bit 9 T=1 mode, bit 8 guard top bit, low byte; guard in units
  logic [9:0] eg_t [3] = '{10'h005, 10'h205, 10'h302};
  int gd_t [3] = '{12, 11, 258};
  sc_guard dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_etu_tick(tick),
    .i_rx_start(rxs), .i_rx_char_done(rxd), .i_rx_char_raw(raw),
    .i_tx_start(tx), .i_card_break(cbrk), .i_card_supply_good(sup),
    .o_tx_start_ok(txok), .o_direct_conv(dconv), .o_card_rst_n(crst),
    .o_irq(irq));
  sc_card_model card_u (.i_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_tick(tick), .i_card_rst_n(crst[0]), .i_mute(mute),
    .i_send(send), .i_brk(brk), .i_byte(tbyte), .o_rx_start(rxs),
    .o_rx_done(rxd), .o_break(cbrk), .o_raw(raw));
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  // --------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------
  task finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      exp_v = expq.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // --------------------------------------------------------------
  // Drivers
  // --------------------------------------------------------------
  task apb(input logic w, input logic [15:0] idx, input logic [7:0] d,
           input logic [32:0] e);
    if (!w) expq.push_back(e);
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge i_core_clk);
    penable <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1) @(posedge i_core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask
  task rd(input logic [15:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, {25'h0, e});
  endtask
  task tick_n(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      tick <= 1'b1;
      @(posedge i_core_clk);
      tick <= 1'b0;
      repeat ($random(seed) & 3) @(posedge i_core_clk);
    end
  endtask
  // 0 transmitted start, 1 card break, 2 received character
  task strobe(input int k);
    @(posedge i_core_clk);
    {send, brk, tx} <= 3'b001 << k;
    @(posedge i_core_clk);
    {send, brk, tx} <= 3'b000;
    repeat (3) @(posedge i_core_clk);
  endtask
  task waitc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, tick, tx, brk, send, sup, i_rst_n} = '0;
    mute = 1'b1;
    paddr = '0;
    pwdata = '0;
    tbyte = 8'h3B;
    waitc(12);
    i_rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(idx_t[i], rst_t[i]);
      v = $random(seed);
      wr(idx_t[i], v[7:0]);
      rd(idx_t[i], v[7:0] & ((i == 0) ? 8'h9F : 8'hFF));
    end
    apb(1'b0, 16'h0000, 8'h00, {1'b1, 32'h0});
    for (j = 0; j < 3; j++) begin
      wr(sc_guard_pkg::IDX_CTRL, {7'h0, eg_t[j][9]});
      wr(sc_guard_pkg::IDX_BLOCK_GUARD, {eg_t[j][8], 7'h16});
      wr(sc_guard_pkg::IDX_EXTRA_GUARD, eg_t[j][7:0]);
      strobe(0);
      tick_n(gd_t[j] - 1);
      rd(sc_guard_pkg::IDX_STATE, 8'h01);
      `CHK(txok, 1'b0)
      tick_n(1);
      rd(sc_guard_pkg::IDX_STATE, 8'h03);
      `CHK(txok, 1'b1)
    end
    wr(sc_guard_pkg::IDX_CTRL, 8'h00);
    wr(sc_guard_pkg::IDX_BLOCK_GUARD, 8'h16);
    strobe(0);
    tick_n(6);
    strobe(1);
    tick_n(11);
    rd(sc_guard_pkg::IDX_STATE, 8'h01);
    tick_n(1);
    rd(sc_guard_pkg::IDX_STATE, 8'h03);
    strobe(2);
    tick_n(21);
    rd(sc_guard_pkg::IDX_STATE, 8'h01);
    tick_n(1);
    rd(sc_guard_pkg::IDX_STATE, 8'h03);
    wr(sc_guard_pkg::IDX_IRQ_MASK, 8'h01);
    wr(sc_guard_pkg::IDX_ANS_TO_HIGH, 8'h00);
    wr(sc_guard_pkg::IDX_ANS_TO_LOW, 8'h05);
    wr(sc_guard_pkg::IDX_CTRL, 8'h04);
    strobe(2);
    tick_n(5);
    rd(sc_guard_pkg::IDX_IRQ_STATUS, 8'h00);
    tick_n(1);
    rd(sc_guard_pkg::IDX_IRQ_STATUS, 8'h01);
    `CHK(irq, 1'b1)
    wr(sc_guard_pkg::IDX_IRQ_MASK, 8'h00);
    waitc(2);
    `CHK(irq, 1'b0)
    wr(sc_guard_pkg::IDX_IRQ_MASK, 8'h01);
    waitc(2);
    `CHK(irq, 1'b1)
    wr(sc_guard_pkg::IDX_CTRL, 8'h00);
    wr(sc_guard_pkg::IDX_IRQ_STATUS, 8'h01);
    waitc(2);
    `CHK(irq, 1'b0)
    wr(sc_guard_pkg::IDX_CTRL, 8'h04);
    tick_n(8);
    rd(sc_guard_pkg::IDX_IRQ_STATUS, 8'h00);
    wr(sc_guard_pkg::IDX_RST_DELAY, 8'h00);
    wr(sc_guard_pkg::IDX_CTRL, 8'h00);
    sup <= 1'b1;
    waitc(8);
    `CHK(crst, 2'b01)
    wr(sc_guard_pkg::IDX_CTRL, 8'h02);
    waitc(4);
    `CHK(crst[0], 1'b0)
    sup <= 1'b0;
    waitc(4);
    sup <= 1'b1;
    waitc(8);
    `CHK(crst[0], 1'b0)
    wr(sc_guard_pkg::IDX_RST_DELAY, 8'h05);
    wr(sc_guard_pkg::IDX_CTRL, 8'h00);
    tick_n(4);
    waitc(4);
    `CHK(crst[0], 1'b0)
    tick_n(1);
    waitc(4);
    `CHK(crst[0], 1'b1)
    wr(sc_guard_pkg::IDX_CTRL, 8'h10);
    tick_n(6);
    waitc(4);
    `CHK(crst, 2'b11)
    wr(sc_guard_pkg::IDX_RST_DELAY, 8'h00);
    wr(sc_guard_pkg::IDX_FIRST_TO, 8'h03);
    wr(sc_guard_pkg::IDX_CTRL, 8'h0A);
    wr(sc_guard_pkg::IDX_CTRL, 8'h08);
    tick_n(8);
    rd(sc_guard_pkg::IDX_IRQ_STATUS, 8'h03);
    wr(sc_guard_pkg::IDX_IRQ_STATUS, 8'h07);
    wr(sc_guard_pkg::IDX_FIRST_TO, 8'h14);
    mute <= 1'b0;
    for (j = 0; j < 2; j++) begin
      tbyte <= (j == 1) ? 8'h3B : 8'h3F;
      wr(sc_guard_pkg::IDX_CTRL, 8'h0A);
      wr(sc_guard_pkg::IDX_CTRL, 8'h08);
      tick_n(14);
      rd(sc_guard_pkg::IDX_IRQ_STATUS, 8'h04);
      rd(sc_guard_pkg::IDX_STATE, {7'h02, j[0]});
      `CHK(dconv, j[0])
      rd(sc_guard_pkg::IDX_CTRL, 8'h00);
      wr(sc_guard_pkg::IDX_IRQ_STATUS, 8'h07);
    end
    finish_test();
  end
endmodule
`default_nettype wire
